// file: verilog/comparator_pkg.sv
// constants for the comparator control register block
// How it works
// - The output state bit reads 1 while the non-inverting input is above the inverting one, is live and ignores writes.
// - A low-to-high change of the comparator output sets the rising-edge flag.
// - Each edge flag stays set until software writes a 0 to it.
// - A high-to-low change of the comparator output sets the falling-edge flag, independently of the rising one.
// - Writing 1 to the enable bit turns the comparator on and writing 0 shuts it down.
// - While disabled, the pin output is held low and edges do not set the flags.
package comparator_pkg;
    localparam logic [7:0] CTRL_ADDR = 8'h9e;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int ENABLE_BIT = 7;
    localparam int STATE_BIT = 6;
    localparam int RISE_BIT = 5;
    localparam int FALL_BIT = 4;
    localparam int HYP_MSB = 3;
    localparam int HYP_LSB = 2;
    localparam int HYN_MSB = 1;
    localparam int HYN_LSB = 0;
    localparam int SETTLE_US = 20;
    localparam int CLOCK_MHZ = 20;
    localparam int SETTLE_CYCLES = SETTLE_US * CLOCK_MHZ;
endpackage : comparator_pkg

// file: verilog/edge_link_if.sv
// synchronised comparator level and its edge pulses
`timescale 1ns/1ns
interface edge_link_if;
    logic state;
    logic rise;
    logic fall;
    modport producer (output state, output rise, output fall);
    modport consumer (input state, input rise, input fall);
endinterface : edge_link_if

// file: verilog/comparator_edge_sync.sv
// two-stage synchroniser and edge detector for the raw comparator output
`timescale 1ns/1ns
module comparator_edge_sync
    import comparator_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic comparator_raw,
    edge_link_if.producer link
);
    logic sync_first;
    logic sync_second;
    logic state_prev;

    // analog result is asynchronous, so two flops before any use
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync_first <= 1'b0;
            sync_second <= 1'b0;
            state_prev <= 1'b0;
        end else begin
            sync_first <= comparator_raw;
            sync_second <= sync_first;
            state_prev <= sync_second;
        end
    end

    // edges taken from settled stages only
    assign link.state = sync_second;
    assign link.rise = sync_second & ~state_prev;
    assign link.fall = ~sync_second & state_prev;
endmodule : comparator_edge_sync

// file: verilog/comparator_control_register.sv
// comparator 0 control register on the special function register bus
`timescale 1ns/1ns
module comparator_control_register
    import comparator_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic comparator_raw,
    output logic [7:0] sfr_rdata,
    output logic comparator_enable,
    output logic [1:0] positive_hysteresis_select,
    output logic [1:0] negative_hysteresis_select,
    output logic comparator_pin_out
);
    edge_link_if link ();

    logic rising_edge_flag;
    logic falling_edge_flag;
    logic next_rise_flag;
    logic next_fall_flag;
    logic [7:0] ctrl_view;

    comparator_edge_sync sync_unit (
        .clock(clock),
        .sys_rst(sys_rst),
        .comparator_raw(comparator_raw),
        .link(link)
    );

    // address decode
    wire write_hit = sfr_wr && (sfr_addr == CTRL_ADDR);
    wire read_hit = (sfr_addr == CTRL_ADDR);

    // edges only count while enabled; a set beats a same-cycle clear,
    // so an edge landing on the clearing write is never lost
    // gated rising edge
    wire rise_event = link.rise & comparator_enable;
    wire fall_event = link.fall & comparator_enable;
    assign next_rise_flag = (write_hit ? sfr_wdata[RISE_BIT] : rising_edge_flag) | rise_event;
    assign next_fall_flag = (write_hit ? sfr_wdata[FALL_BIT] : falling_edge_flag) | fall_event;

    assign ctrl_view = {comparator_enable, link.state, rising_edge_flag, falling_edge_flag,
                        positive_hysteresis_select, negative_hysteresis_select};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            comparator_enable <= CTRL_RESET[ENABLE_BIT];
        end else if (write_hit) begin
            comparator_enable <= sfr_wdata[ENABLE_BIT];
        end
    end

    // hysteresis field storage
    // the analog macro reads these flops directly, no extra staging
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            positive_hysteresis_select <= CTRL_RESET[HYP_MSB:HYP_LSB];
            negative_hysteresis_select <= CTRL_RESET[HYN_MSB:HYN_LSB];
        end else if (write_hit) begin
            positive_hysteresis_select <= sfr_wdata[HYP_MSB:HYP_LSB];
            negative_hysteresis_select <= sfr_wdata[HYN_MSB:HYN_LSB];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rising_edge_flag <= CTRL_RESET[RISE_BIT];
            falling_edge_flag <= CTRL_RESET[FALL_BIT];
        end else begin
            rising_edge_flag <= next_rise_flag;
            falling_edge_flag <= next_fall_flag;
        end
    end

    // registered read data; other addresses read as zero
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
        end else begin
            sfr_rdata <= read_hit ? ctrl_view : 8'h00;
        end
    end

    // pin low when off
    // one flop after the synchroniser, so the pin lags the state bit by a cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            comparator_pin_out <= 1'b0;
        end else begin
            comparator_pin_out <= comparator_enable & link.state;
        end
    end

    // software waits SETTLE_CYCLES after enable; nothing here masks it
    // the settle time is a software duty: a hardware mask would hide a
    // genuine early edge and cost a wide counter for no gain

    // checks below watch design signals and the bus and comparator inputs, quiet during reset

    state_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        read_hit |=> sfr_rdata[STATE_BIT] == $past(link.state))
        else $error("state bit does not follow comparator");

    rise_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        link.rise && comparator_enable |=> rising_edge_flag)
        else $error("rising edge did not set flag");

    flag_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        rising_edge_flag && !(write_hit && !sfr_wdata[RISE_BIT]) |=> rising_edge_flag [*1])
        else $error("rising flag lost without clear");

    fall_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        link.fall && comparator_enable |=> falling_edge_flag && ($stable(rising_edge_flag) || $past(write_hit)))
        else $error("falling edge did not set flag");

    enable_write_a: assert property (@(posedge clock) disable iff (sys_rst)
        write_hit |=> comparator_enable == $past(sfr_wdata[ENABLE_BIT]))
        else $error("enable bit not stored");

    pin_off_a: assert property (@(posedge clock) disable iff (sys_rst)
        !comparator_enable |=> !comparator_pin_out)
        else $error("pin not low while disabled");

    no_flag_off_a: assert property (@(posedge clock) disable iff (sys_rst)
        !comparator_enable && !write_hit && !rising_edge_flag && !falling_edge_flag
            |=> !rising_edge_flag && !falling_edge_flag)
        else $error("flag set while disabled");

    hyst_drive_a: assert property (@(posedge clock) disable iff (sys_rst)
        write_hit |=> {positive_hysteresis_select, negative_hysteresis_select}
            == $past(sfr_wdata[HYP_MSB:HYN_LSB]))
        else $error("hysteresis fields not driven");

    hyst_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        !write_hit |=> $stable({positive_hysteresis_select, negative_hysteresis_select}))
        else $error("hysteresis fields changed without a write");

    hyst_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        read_hit |=> sfr_rdata[HYP_MSB:HYN_LSB]
            == $past({positive_hysteresis_select, negative_hysteresis_select}))
        else $error("hysteresis fields read back wrong");

    enable_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        !write_hit |=> $stable(comparator_enable))
        else $error("enable bit changed without a write");

    enable_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        read_hit |=> sfr_rdata[ENABLE_BIT] == $past(comparator_enable))
        else $error("enable bit read back wrong");

    fall_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        falling_edge_flag && !(write_hit && !sfr_wdata[FALL_BIT]) |=> falling_edge_flag)
        else $error("falling flag lost without clear");

    rise_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        write_hit && !sfr_wdata[RISE_BIT] && !rise_event |=> !rising_edge_flag)
        else $error("rising flag not cleared by a zero");

    fall_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        write_hit && !sfr_wdata[FALL_BIT] && !fall_event |=> !falling_edge_flag)
        else $error("falling flag not cleared by a zero");

    rise_cause_a: assert property (@(posedge clock) disable iff (sys_rst)
        !rising_edge_flag && !write_hit && !link.rise |=> !rising_edge_flag)
        else $error("rising flag set with no edge");

    fall_cause_a: assert property (@(posedge clock) disable iff (sys_rst)
        !falling_edge_flag && !write_hit && !link.fall |=> !falling_edge_flag)
        else $error("falling flag set with no edge");

    flag_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        read_hit |=> sfr_rdata[RISE_BIT:FALL_BIT] == $past({rising_edge_flag, falling_edge_flag}))
        else $error("edge flags read back wrong");

    flag_apart_a: assert property (@(posedge clock) disable iff (sys_rst)
        link.rise && !write_hit |=> $stable(falling_edge_flag))
        else $error("rising edge touched the falling flag");

    rise_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        link.rise && !comparator_enable && !write_hit |=> $stable(rising_edge_flag))
        else $error("rising edge counted while disabled");

    fall_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        link.fall && !comparator_enable && !write_hit |=> $stable(falling_edge_flag))
        else $error("falling edge counted while disabled");

    pin_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
        comparator_enable |=> comparator_pin_out == $past(link.state))
        else $error("pin does not follow comparator");

    state_track_a: assert property (@(posedge clock) disable iff (sys_rst)
        1'b1 |-> ##2 link.state == $past(comparator_raw, 2))
        else $error("state bit lags the comparator");
endmodule : comparator_control_register

// file: tb/comparator_model.sv
// analog comparator stand-in that produces the raw result
`timescale 1ns/1ns
module comparator_model (
    input wire logic [7:0] plus_level,
    input wire logic [7:0] minus_level,
    output logic comparator_raw
);
    // strict compare, so equal inputs read low
    assign comparator_raw = plus_level > minus_level;
endmodule : comparator_model

// file: tb/comparator_control_register_bench.sv
// self-checking bench for the comparator control register
`timescale 1ns/1ns
module comparator_control_register_bench;
    import comparator_pkg::*;
    logic clock = 0, sys_rst = 1, sfr_wr = 0, raw, en, pin;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rdata, plus = 8'h00, minus = 8'h80;
    logic [1:0] hyp, hyn;
    int mismatches = 0, num_checks = 0;
    always #25 clock = ~clock;
    comparator_model partner (.plus_level(plus), .minus_level(minus), .comparator_raw(raw));
    comparator_control_register DUT (.clock(clock), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .comparator_raw(raw), .sfr_rdata(rdata),
        .comparator_enable(en), .positive_hysteresis_select(hyp),
        .negative_hysteresis_select(hyn), .comparator_pin_out(pin));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // one-cycle write strobe, taken at the second edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clock);
        sfr_wr <= 1'b0;
        #1;
    endtask : wr
    // read data is registered, so look one cycle after the sampling edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        sfr_addr <= a;
        repeat (2) @(posedge clock);
        #1 cmp(rdata, exp);
    endtask : rd
    // synchroniser plus edge flop takes three edges; allow four
    task automatic level(input logic [7:0] v);
        @(posedge clock);
        plus <= v;
        repeat (4) @(posedge clock);
    endtask : level
    task automatic check_reset;
        rd(CTRL_ADDR, CTRL_RESET);
        cmp({7'h00, en}, 8'h00);
    endtask : check_reset
    task automatic check_fields;
        wr(CTRL_ADDR, 8'h8d);
        cmp({3'h0, en, hyp, hyn}, 8'h1d);
        // state and flags are not trusted until the comparator settles
        repeat (SETTLE_CYCLES) @(posedge clock);
        wr(8'h9f, 8'h00);
        rd(CTRL_ADDR, 8'h8d);
        rd(8'h9f, 8'h00);
    endtask : check_fields
    task automatic check_edges;
        level(8'hff);
        rd(CTRL_ADDR, 8'hed);
        cmp({7'h00, pin}, 8'h01);
        level(8'h00);
        rd(CTRL_ADDR, 8'hbd);
        wr(CTRL_ADDR, 8'hcd);
        rd(CTRL_ADDR, 8'h8d);
    endtask : check_edges
    task automatic check_disabled;
        wr(CTRL_ADDR, 8'h00);
        level(8'hff);
        rd(CTRL_ADDR, 8'h40);
        cmp({7'h00, pin}, 8'h00);
        level(8'h00);
        rd(CTRL_ADDR, 8'h00);
        // software may set the flags; other hysteresis codes too
        wr(CTRL_ADDR, 8'h36);
        rd(CTRL_ADDR, 8'h36);
        cmp({4'h0, hyp, hyn}, 8'h06);
    endtask : check_disabled
    // second reset in mid-run must clear fields and flags
    task automatic check_midreset;
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        check_reset;
        cmp({4'h0, hyp, hyn}, 8'h00);
    endtask : check_midreset
    task automatic finish_test;
        if (mismatches == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    // reset for four cycles, then every scenario in turn
    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        check_reset;
        check_fields;
        check_edges;
        check_disabled;
        check_midreset;
        finish_test;
    end
endmodule : comparator_control_register_bench
